/* File: src/asf_pkg.sv */
// Package of constants and carrier types for the ATA seek/features/power command decoder
package asf_pkg;
    // Register byte addresses (index times four)
    localparam logic [5:0] ADR_FEATURE = 6'h04;
    localparam logic [5:0] ADR_SECCNT = 6'h08;
    localparam logic [5:0] ADR_SECNUM = 6'h0c;
    localparam logic [5:0] ADR_CYLLO = 6'h10;
    localparam logic [5:0] ADR_CYLHI = 6'h14;
    localparam logic [5:0] ADR_DRVHD = 6'h18;
    localparam logic [5:0] ADR_CMD = 6'h1c;
    // Own registers: status, settings, seek address, error code, transfer modes
    // Six address bits, since the map runs past byte 0x1f
    localparam logic [5:0] ADR_STATUS = 6'h00;
    localparam logic [5:0] ADR_SETTINGS = 6'h20;
    localparam logic [5:0] ADR_SEEK = 6'h24;
    localparam logic [5:0] ADR_ERROR = 6'h28;
    localparam logic [5:0] ADR_XFER = 6'h2c;
    // Opcodes
    localparam logic [3:0] OP_SEEK_HI = 4'h7;
    localparam logic [7:0] OP_SETFEAT = 8'hef;
    localparam logic [7:0] OP_SETMULT = 8'hc6;
    localparam logic [7:0] OP_SLEEP_A = 8'h99;
    localparam logic [7:0] OP_SLEEP_B = 8'he6;
    localparam logic [7:0] OP_STBY_A = 8'h96;
    localparam logic [7:0] OP_STBY_B = 8'he2;
    // Feature sub-codes
    localparam logic [7:0] FT_8BIT_ON = 8'h01;
    localparam logic [7:0] FT_8BIT_OFF = 8'h81;
    localparam logic [7:0] FT_WC_ON = 8'h02;
    localparam logic [7:0] FT_WC_OFF = 8'h82;
    localparam logic [7:0] FT_XFER = 8'h03;
    localparam logic [7:0] FT_APM_ON = 8'h05;
    localparam logic [7:0] FT_APM_OFF = 8'h85;
    localparam logic [7:0] FT_XPW_ON = 8'h09;
    localparam logic [7:0] FT_XPW_OFF = 8'h89;
    localparam logic [7:0] FT_PL1_ON = 8'h0a;
    localparam logic [7:0] FT_PL1_OFF = 8'h8a;
    localparam logic [7:0] FT_ECC_VS = 8'h44;
    localparam logic [7:0] FT_RLA_OFF = 8'h55;
    localparam logic [7:0] FT_RLA_ON = 8'haa;
    localparam logic [7:0] FT_POR_OFF = 8'h66;
    localparam logic [7:0] FT_POR_ON = 8'hcc;
    localparam logic [7:0] FT_NOP_A = 8'h69;
    localparam logic [7:0] FT_NOP_B = 8'h96;
    localparam logic [7:0] FT_NOP_C = 8'h97;
    localparam logic [7:0] FT_CURSRC = 8'h9a;
    localparam logic [7:0] FT_ECC_4 = 8'hbb;
    // Transfer type field (upper five bits of sector count)
    localparam logic [4:0] XT_PIO_DEF = 5'h00;
    localparam logic [4:0] XT_PIO_FC = 5'h01;
    localparam logic [4:0] XT_MDMA = 5'h04;
    // Error codes
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_INVALID = 8'h20;
    // Drive/head bit positions: two fixed-one bits, LBA, drive
    localparam int DH_ONE_HI = 7;
    localparam int DH_LBA = 6;
    localparam int DH_ONE_LO = 5;
    localparam int DH_DRV = 4;
    // Flush duration after write cache disable
    localparam int FLUSH_NS = 100;
    localparam int CLK_NS = 5;
    localparam logic [7:0] FLUSH_CYC = 8'(FLUSH_NS / CLK_NS);
    // Reset values of settings
    localparam logic [2:0] PIO_MODE_RST = 3'h0;
    localparam logic [2:0] MDMA_MODE_RST = 3'h0;
    localparam logic [7:0] MULT_RST = 8'h00;

    // Command state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FLUSH = 2'b01,
        ST_DONE = 2'b10
    } asf_state_t;

    // Device settings
    typedef struct packed {
        logic eight_bit;
        logic wcache;
        logic apm;
        logic xpower;
        logic pl1;
        logic rla;
        logic por_defaults;
        logic ecc_vendor;
        logic [2:0] pio_mode;
        logic [2:0] mdma_mode;
        logic [7:0] current_cap;
        logic [7:0] mult_count;
    } asf_cfg_t;

    // Task file parameter registers
    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] seccnt;
        logic [7:0] secnum;
        logic [7:0] cyllo;
        logic [7:0] cylhi;
        logic [7:0] drvhd;
    } asf_tf_t;

    // Whole module state
    typedef struct packed {
        asf_state_t st;
        asf_tf_t tf;
        asf_cfg_t cfg;
        logic [7:0] opcode;
        logic [7:0] err;
        logic [7:0] flush_cnt;
        logic busy;
        logic sleep;
        logic standby;
        logic [27:0] seek_lba;
        logic seek_lba_mode;
        logic seek_drive;
        logic [31:0] rdata;
        logic rvalid;
    } asf_state_all_t;
endpackage

/* File: src/asf_cmd.sv */
// Command decoder for seek, set features, set multiple, sleep and standby
// Overview of operation
// - Seek opcode 7x; cylinders carry LBA 23-8
// - Seek drive/head: bits 7,5 one; LBA, drive
// - Feature 01h selects 8-bit low-lane transfers
// - 8-bit mode keeps wide indicator off; 81h undoes
// - Features 02h/82h enable, disable write cache
// - Cache disable flushes before completion
// - Feature 03h sets mode: type, number fields
// - Exactly one PIO mode always selected
// - Exactly one multiword DMA mode selected
// - Features 05h/85h toggle advanced power management
// - Features 09h/89h toggle extended power operations
// - Features 0Ah/8Ah permit or forbid power level 1
// - Features 55h/AAh turn look-ahead off, on
// - Features 66h/CCh control soft-reset defaults
// - Features 69h, 96h, 97h accepted, no effect
// - BBh four long bytes; 44h vendor ECC bytes
// - Feature 9Ah stores host current capability
// - Opcode C6h sets block size from count
// - Opcodes 99h, E6h mean sleep
// - Opcodes 96h, E2h mean standby
// - Failure puts error code, 20h invalid
`timescale 1ns/1ps
`default_nettype none
module asf_cmd (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic data_reg_access,
    input wire logic soft_reset,
    output logic wide_io_indicator,
    output logic eight_bit_mode,
    output logic sleep_mode,
    output logic standby_mode,
    output logic cmd_busy
);
    // Full register state and its next value
    asf_pkg::asf_state_all_t s_q;
    asf_pkg::asf_state_all_t s_d;
    // Power-on defaults of the settings block
    asf_pkg::asf_cfg_t cfg_rst;
    // Mode field of sector count
    logic [4:0] xfer_type;
    logic [2:0] xfer_mode;

    // True when a feature code is in the supported set
    function automatic logic feat_known(input logic [7:0] f);
        unique case (f)
            asf_pkg::FT_8BIT_ON, asf_pkg::FT_8BIT_OFF, asf_pkg::FT_WC_ON,
            asf_pkg::FT_WC_OFF, asf_pkg::FT_XFER, asf_pkg::FT_APM_ON,
            asf_pkg::FT_APM_OFF, asf_pkg::FT_XPW_ON, asf_pkg::FT_XPW_OFF,
            asf_pkg::FT_PL1_ON, asf_pkg::FT_PL1_OFF, asf_pkg::FT_ECC_VS,
            asf_pkg::FT_RLA_OFF, asf_pkg::FT_RLA_ON, asf_pkg::FT_POR_OFF,
            asf_pkg::FT_POR_ON, asf_pkg::FT_NOP_A, asf_pkg::FT_NOP_B,
            asf_pkg::FT_NOP_C, asf_pkg::FT_CURSRC, asf_pkg::FT_ECC_4: feat_known = 1'b1;
            default: feat_known = 1'b0;
        endcase
    endfunction

    // Read data for one word address
    function automatic logic [31:0] rd_mux(input asf_pkg::asf_state_all_t s,
                                           input logic [5:0] a);
        unique case (a)
            asf_pkg::ADR_SECCNT: rd_mux = {24'h000000, s.tf.seccnt};
            asf_pkg::ADR_SECNUM: rd_mux = {24'h000000, s.tf.secnum};
            asf_pkg::ADR_CYLLO: rd_mux = {24'h000000, s.tf.cyllo};
            asf_pkg::ADR_CYLHI: rd_mux = {24'h000000, s.tf.cylhi};
            asf_pkg::ADR_DRVHD: rd_mux = {24'h000000, s.tf.drvhd};
            asf_pkg::ADR_STATUS: rd_mux = {28'h0000000, s.standby, s.sleep,
                                          (s.err != asf_pkg::ERR_NONE), s.busy};
            asf_pkg::ADR_SETTINGS: rd_mux = {24'h000000, s.cfg.ecc_vendor,
                s.cfg.por_defaults, s.cfg.rla, s.cfg.pl1, s.cfg.xpower,
                s.cfg.apm, s.cfg.wcache, s.cfg.eight_bit};
            asf_pkg::ADR_SEEK: rd_mux = {2'h0, s.seek_drive, s.seek_lba_mode, s.seek_lba};
            asf_pkg::ADR_ERROR: rd_mux = {24'h000000, s.err};
            asf_pkg::ADR_XFER: rd_mux = {10'h000, s.cfg.mdma_mode, s.cfg.pio_mode,
                                        s.cfg.current_cap, s.cfg.mult_count};
            default: rd_mux = 32'h00000000;
        endcase
    endfunction

    // Settings after power-on reset or a soft reset with defaults enabled
    always_comb begin
        cfg_rst = '0;
        cfg_rst.rla = 1'b1;
        cfg_rst.por_defaults = 1'b1;
        cfg_rst.pio_mode = asf_pkg::PIO_MODE_RST;
        cfg_rst.mdma_mode = asf_pkg::MDMA_MODE_RST;
        cfg_rst.mult_count = asf_pkg::MULT_RST;
    end

    assign xfer_type = s_q.tf.seccnt[7:3];
    assign xfer_mode = s_q.tf.seccnt[2:0];

    // Next-state logic: bus access, command decode, flush timing
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        // Bus read: one wait cycle, then data from the registered copy
        if (avs_read && !s_q.rvalid) begin
            s_d.rdata = rd_mux(s_q, avs_address);
            s_d.rvalid = 1'b1;
        end
        // Soft reset restores defaults only when enabled
        if (soft_reset && s_q.cfg.por_defaults) begin
            s_d.cfg = cfg_rst;
        end
        // Parameter writes, ignored while a command runs
        if (avs_write && avs_byteenable[0] && !s_q.busy) begin
            unique case (avs_address)
                asf_pkg::ADR_FEATURE: s_d.tf.feature = avs_writedata[7:0];
                asf_pkg::ADR_SECCNT: s_d.tf.seccnt = avs_writedata[7:0];
                asf_pkg::ADR_SECNUM: s_d.tf.secnum = avs_writedata[7:0];
                asf_pkg::ADR_CYLLO: s_d.tf.cyllo = avs_writedata[7:0];
                asf_pkg::ADR_CYLHI: s_d.tf.cylhi = avs_writedata[7:0];
                asf_pkg::ADR_DRVHD: s_d.tf.drvhd = avs_writedata[7:0];
                asf_pkg::ADR_CMD: begin
                    s_d.opcode = avs_writedata[7:0];
                    s_d.busy = 1'b1;
                    s_d.st = asf_pkg::ST_DONE;
                end
                default: begin
                end
            endcase
        end
        // Command execution
        unique case (s_q.st)
            asf_pkg::ST_IDLE: begin
            end
            asf_pkg::ST_DONE: begin
                s_d.err = asf_pkg::ERR_NONE;
                s_d.busy = 1'b0;
                s_d.st = asf_pkg::ST_IDLE;
                if (s_q.opcode[7:4] == asf_pkg::OP_SEEK_HI) begin
                    // Bits 7 and 5 must be one
                    if (s_q.tf.drvhd[asf_pkg::DH_ONE_HI] && s_q.tf.drvhd[asf_pkg::DH_ONE_LO]) begin
                        s_d.seek_lba = {s_q.tf.drvhd[3:0], s_q.tf.cylhi,
                                        s_q.tf.cyllo, s_q.tf.secnum};
                        s_d.seek_lba_mode = s_q.tf.drvhd[asf_pkg::DH_LBA];
                        s_d.seek_drive = s_q.tf.drvhd[asf_pkg::DH_DRV];
                        s_d.sleep = 1'b0;
                        s_d.standby = 1'b0;
                    end else begin
                        s_d.err = asf_pkg::ERR_INVALID;
                    end
                end else if (s_q.opcode == asf_pkg::OP_SETMULT) begin
                    s_d.cfg.mult_count = s_q.tf.seccnt;
                end else if (s_q.opcode == asf_pkg::OP_SLEEP_A ||
                             s_q.opcode == asf_pkg::OP_SLEEP_B) begin
                    s_d.sleep = 1'b1;
                    s_d.standby = 1'b0;
                end else if (s_q.opcode == asf_pkg::OP_STBY_A ||
                             s_q.opcode == asf_pkg::OP_STBY_B) begin
                    s_d.standby = 1'b1;
                    s_d.sleep = 1'b0;
                end else if (s_q.opcode == asf_pkg::OP_SETFEAT) begin
                    if (!feat_known(s_q.tf.feature)) begin
                        s_d.err = asf_pkg::ERR_INVALID;
                    end else begin
                        unique case (s_q.tf.feature)
                            asf_pkg::FT_8BIT_ON: s_d.cfg.eight_bit = 1'b1;
                            asf_pkg::FT_8BIT_OFF: s_d.cfg.eight_bit = 1'b0;
                            asf_pkg::FT_WC_ON: s_d.cfg.wcache = 1'b1;
                            asf_pkg::FT_WC_OFF: begin
                                // Stay busy until the cache flush ends
                                s_d.cfg.wcache = 1'b0;
                                s_d.busy = 1'b1;
                                s_d.flush_cnt = asf_pkg::FLUSH_CYC;
                                s_d.st = asf_pkg::ST_FLUSH;
                            end
                            asf_pkg::FT_XFER: begin
                                // One field always holds exactly one mode number
                                if (xfer_type == asf_pkg::XT_PIO_DEF ||
                                    xfer_type == asf_pkg::XT_PIO_FC) begin
                                    s_d.cfg.pio_mode = xfer_mode;
                                end else if (xfer_type == asf_pkg::XT_MDMA) begin
                                    s_d.cfg.mdma_mode = xfer_mode;
                                end else begin
                                    s_d.err = asf_pkg::ERR_INVALID;
                                end
                            end
                            asf_pkg::FT_APM_ON: s_d.cfg.apm = 1'b1;
                            asf_pkg::FT_APM_OFF: s_d.cfg.apm = 1'b0;
                            asf_pkg::FT_XPW_ON: s_d.cfg.xpower = 1'b1;
                            asf_pkg::FT_XPW_OFF: s_d.cfg.xpower = 1'b0;
                            asf_pkg::FT_PL1_ON: s_d.cfg.pl1 = 1'b1;
                            asf_pkg::FT_PL1_OFF: s_d.cfg.pl1 = 1'b0;
                            asf_pkg::FT_RLA_OFF: s_d.cfg.rla = 1'b0;
                            asf_pkg::FT_RLA_ON: s_d.cfg.rla = 1'b1;
                            asf_pkg::FT_POR_OFF: s_d.cfg.por_defaults = 1'b0;
                            asf_pkg::FT_POR_ON: s_d.cfg.por_defaults = 1'b1;
                            asf_pkg::FT_ECC_4: s_d.cfg.ecc_vendor = 1'b0;
                            asf_pkg::FT_ECC_VS: s_d.cfg.ecc_vendor = 1'b1;
                            asf_pkg::FT_CURSRC: s_d.cfg.current_cap = s_q.tf.seccnt;
                            default: begin
                                // No-op codes are accepted silently
                            end
                        endcase
                    end
                end else begin
                    s_d.err = asf_pkg::ERR_INVALID;
                end
            end
            asf_pkg::ST_FLUSH: begin
                // Completion only after the flush time has passed
                if (s_q.flush_cnt <= 8'h01) begin
                    s_d.busy = 1'b0;
                    s_d.st = asf_pkg::ST_IDLE;
                end else begin
                    s_d.flush_cnt = s_q.flush_cnt - 8'h01;
                end
            end
            default: s_d.st = asf_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.cfg.rla <= 1'b1;
            s_q.cfg.por_defaults <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Writes complete at once; reads wait one cycle for registered data
    assign avs_waitrequest = avs_read && !s_q.rvalid;
    assign avs_readdata = s_q.rdata;
    // Wide indicator never asserts in 8-bit mode
    assign wide_io_indicator = data_reg_access && !s_q.cfg.eight_bit;
    assign eight_bit_mode = s_q.cfg.eight_bit;
    assign sleep_mode = s_q.sleep;
    assign standby_mode = s_q.standby;
    assign cmd_busy = s_q.busy;
endmodule
`default_nettype wire

/* File: dv/asf_cmd_sva.sv */
// Checker for the decoder's bus handshake, command timing and mode outputs
`timescale 1ns/1ps
`default_nettype none
module asf_cmd_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic data_reg_access,
    input wire logic soft_reset,
    input wire logic wide_io_indicator,
    input wire logic eight_bit_mode,
    input wire logic sleep_mode,
    input wire logic standby_mode,
    input wire logic cmd_busy
);
    logic [7:0] feat_q; // Feature byte last taken by the task file
    logic wr_ok; // A write the decoder takes (low lane enabled, not busy)
    logic cmd_go; // A command write that starts execution
    logic set_go; // A set-features command starting
    logic [7:0] op; // Byte on the write lane
    assign op = avs_writedata[7:0];
    assign wr_ok = avs_write && avs_byteenable[0] && !cmd_busy;
    assign cmd_go = wr_ok && avs_address == asf_pkg::ADR_CMD;
    assign set_go = cmd_go && op == asf_pkg::OP_SETFEAT;
    // Shadow of the feature register; busy writes are dropped as in the device
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            feat_q <= 8'h00;
        end else if (wr_ok && avs_address == asf_pkg::ADR_FEATURE) begin
            feat_q <= op;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_WIDE_IO: assert property (
        wide_io_indicator == (data_reg_access && !eight_bit_mode))
        else $error("wide io indicator wrong");
    AST_RD_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read answer not after one wait cycle");
    AST_WR_NOWAIT: assert property (avs_write |-> !avs_waitrequest)
        else $error("write was stalled");
    AST_CMD_BUSY: assert property (cmd_go |=> cmd_busy)
        else $error("command not taken");
    AST_BUSY_END: assert property ($rose(cmd_busy) |-> ##[1:40] !cmd_busy)
        else $error("busy never ended");
    AST_8BIT_ON: assert property (
        set_go && feat_q == asf_pkg::FT_8BIT_ON |-> ##2 eight_bit_mode)
        else $error("8-bit mode not entered");
    AST_8BIT_OFF: assert property (
        set_go && feat_q == asf_pkg::FT_8BIT_OFF |-> ##2 !eight_bit_mode)
        else $error("8-bit mode not left");
    AST_FLUSH: assert property (
        set_go && feat_q == asf_pkg::FT_WC_OFF |=>
        cmd_busy[*8] ##1 cmd_busy[*8] ##1 cmd_busy[*4])
        else $error("completion before cache flush");
    AST_SLEEP: assert property (cmd_go && op inside {8'h99, 8'he6} |-> ##2 sleep_mode)
        else $error("sleep not entered");
    AST_STBY: assert property (cmd_go && op inside {8'h96, 8'he2} |-> ##2 standby_mode)
        else $error("standby not entered");
    AST_NOP: assert property (
        set_go && feat_q inside {8'h69, 8'h96, 8'h97} |=> $stable(eight_bit_mode)[*2])
        else $error("no-op feature changed mode");
    COV_FLUSH: cover property (set_go && feat_q == asf_pkg::FT_WC_OFF);
    COV_SLEEP: cover property (cmd_go && op == asf_pkg::OP_SLEEP_B);
    COV_READ: cover property (avs_read && !avs_waitrequest);
endmodule
`default_nettype wire

/* File: dv/asf_host.sv */
// Host controller model: drives the task file over the register bus
`timescale 1ns/1ps
`default_nettype none
module asf_host (
    input wire logic clk,
    output logic [5:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    output logic data_reg_access,
    output logic soft_reset
);
    // Idle bus at time zero; only the low byte lane is ever used
    initial begin
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h1;
        data_reg_access = 1'b0;
        soft_reset = 1'b0;
    end
    // One transfer, held until waitrequest is seen low; a gap edge follows
    // Never enables 8-bit mode together with DMA use: no DMA is issued
    // No cycle limit here: a stuck slave is caught by the bench watchdog
    task automatic xfer(input logic wr, input logic [5:0] adr, input logic [7:0] d,
                        output logic [31:0] q);
        avs_address <= adr;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h000000, d};
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: dv/asf_cmd_tb.sv */
// Self-checking bench for the seek, features and power command decoder
`timescale 1ns/1ps
`default_nettype none
module asf_cmd_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    wire logic [5:0] adr;
    wire logic rd_s, wr_s, waitreq, dra, srst, wide, eight, slp, stby, busy;
    wire logic [31:0] wdata, rdata;
    wire logic [3:0] be;
    int n_errors = 0;
    int n_compared = 0;
    int busy_n; // Cycles busy after the last command
    logic [31:0] rd; // Last read word
    logic [7:0] err; // Error code after the last command
    logic [7:0] exp_set = 8'h60; // Expected settings: look-ahead, soft-reset defaults
    always #2.5 clk = ~clk;
    asf_host host (.clk(clk), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
        .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .data_reg_access(dra), .soft_reset(srst));
    asf_cmd dut (.clk(clk), .arst_n(arst_n), .avs_address(adr), .avs_read(rd_s),
        .avs_write(wr_s), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .data_reg_access(dra), .soft_reset(srst),
        .wide_io_indicator(wide), .eight_bit_mode(eight), .sleep_mode(slp),
        .standby_mode(stby), .cmd_busy(busy));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d, rd);
    endtask
    task automatic rr(input logic [5:0] a);
        host.xfer(1'b0, a, 8'h00, rd);
    endtask
    // Load feature and count, issue opcode, wait out busy, fetch error code
    task automatic cmd(input logic [7:0] op, input logic [7:0] ft, input logic [7:0] cnt);
        wr(asf_pkg::ADR_FEATURE, ft);
        wr(asf_pkg::ADR_SECCNT, cnt);
        wr(asf_pkg::ADR_CMD, op);
        busy_n = 0;
        while (busy !== 1'b0 && busy_n < 100) begin
            @(posedge clk);
            busy_n++;
        end
        rr(asf_pkg::ADR_ERROR);
        err = rd[7:0];
    endtask
    // Reset values, status and an unmapped place
    task automatic t_reset();
        rr(asf_pkg::ADR_SETTINGS);
        check("settings", rd, 32'h00000060);
        rr(asf_pkg::ADR_XFER);
        check("xfer", rd, 32'h00000000);
        wr(6'h30, 8'hff);
        rr(6'h30);
        check("unmapped", rd, 32'h00000000);
        rr(asf_pkg::ADR_STATUS);
        check("status", rd, 32'h00000000);
    endtask
    // Every on/off sub-code in turn, indicator watched with data access held
    task automatic t_features();
        logic [7:0] codes [16] = '{8'h01, 8'h81, 8'h02, 8'h82, 8'h05, 8'h85, 8'h09, 8'h89,
                                   8'h0a, 8'h8a, 8'h55, 8'haa, 8'h66, 8'hcc, 8'h44, 8'hbb};
        logic [15:0] vals = 16'h6955;
        host.data_reg_access <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            cmd(asf_pkg::OP_SETFEAT, codes[i], 8'h00);
            exp_set[i / 2] = vals[i];
            rr(asf_pkg::ADR_SETTINGS);
            check("set", rd, {24'h0, exp_set});
            check("wide", {wide, eight}, {!exp_set[0], exp_set[0]});
            if (i == 3) check("flush", 32'(busy_n >= asf_pkg::FLUSH_CYC), 32'h1);
        end
        host.data_reg_access <= 1'b0;
    endtask
    // No-op sub-codes accepted, an unknown one and an unknown opcode refused
    task automatic t_nop_bad();
        logic [7:0] codes [4] = '{8'h69, 8'h96, 8'h97, 8'h33};
        for (int i = 0; i < 4; i++) begin
            cmd(asf_pkg::OP_SETFEAT, codes[i], 8'h00);
            check("err", err, (i == 3) ? asf_pkg::ERR_INVALID : asf_pkg::ERR_NONE);
            rr(asf_pkg::ADR_SETTINGS);
            check("set", rd, {24'h0, exp_set});
        end
        cmd(8'h5b, 8'h00, 8'h00);
        check("err", err, asf_pkg::ERR_INVALID);
        // Status shows the failed command through its error bit
        rr(asf_pkg::ADR_STATUS);
        check("status", rd, 32'h00000002);
    endtask
    // Transfer modes, bad type, current capability, block size
    task automatic t_modes();
        cmd(asf_pkg::OP_SETFEAT, asf_pkg::FT_XFER, {asf_pkg::XT_PIO_FC, 3'h4});
        cmd(asf_pkg::OP_SETFEAT, asf_pkg::FT_XFER, {asf_pkg::XT_MDMA, 3'h2});
        cmd(asf_pkg::OP_SETFEAT, asf_pkg::FT_XFER, {5'h02, 3'h1});
        check("err", err, asf_pkg::ERR_INVALID);
        cmd(asf_pkg::OP_SETFEAT, asf_pkg::FT_CURSRC, 8'h5a);
        cmd(asf_pkg::OP_SETMULT, 8'h00, 8'h10);
        rr(asf_pkg::ADR_XFER);
        check("xfer", rd, {10'h0, 3'h2, 3'h4, 8'h5a, 8'h10});
    endtask
    // Seek address, both sleep and both standby opcodes, bad drive/head
    task automatic t_seek_power();
        logic [7:0] ops [4] = '{8'h99, 8'he6, 8'h96, 8'he2};
        wr(asf_pkg::ADR_DRVHD, 8'he5);
        wr(asf_pkg::ADR_CYLHI, 8'h12);
        wr(asf_pkg::ADR_CYLLO, 8'h34);
        wr(asf_pkg::ADR_SECNUM, 8'h56);
        cmd(8'h7a, 8'h00, 8'h00);
        rr(asf_pkg::ADR_SEEK);
        check("seek", rd, 32'h15123456);
        for (int i = 0; i < 4; i++) begin
            cmd(ops[i], 8'h00, 8'h00);
            check("power", {slp, stby, err}, {i < 2, i >= 2, 8'h00});
            cmd(8'h70, 8'h00, 8'h00);
        end
        wr(asf_pkg::ADR_DRVHD, 8'h45);
        cmd(8'h70, 8'h00, 8'h00);
        check("err", err, asf_pkg::ERR_INVALID);
    endtask
    task automatic pulse_srst();
        host.soft_reset <= 1'b1;
        @(posedge clk);
        host.soft_reset <= 1'b0;
        @(posedge clk);
        rr(asf_pkg::ADR_SETTINGS);
    endtask
    // Soft reset restores defaults only while that is enabled
    task automatic t_soft_reset();
        cmd(asf_pkg::OP_SETFEAT, asf_pkg::FT_APM_ON, 8'h00);
        pulse_srst();
        check("srst", rd, 32'h00000060);
        cmd(asf_pkg::OP_SETFEAT, asf_pkg::FT_POR_OFF, 8'h00);
        cmd(asf_pkg::OP_SETFEAT, asf_pkg::FT_APM_ON, 8'h00);
        pulse_srst();
        check("srst", rd, 32'h00000024);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_features();
        t_nop_bad();
        t_modes();
        t_seek_power();
        t_soft_reset();
        complete_run();
    end
    // Watchdog well past the expected run length
    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
endmodule
bind asf_cmd asf_cmd_sva u_sva (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .data_reg_access(data_reg_access),
    .soft_reset(soft_reset), .wide_io_indicator(wide_io_indicator),
    .eight_bit_mode(eight_bit_mode), .sleep_mode(sleep_mode),
    .standby_mode(standby_mode), .cmd_busy(cmd_busy));
`default_nettype wire
